// ---- src/lvdc_params.svh ----
`ifndef LVDC_PARAMS_SVH
`define LVDC_PARAMS_SVH

// register index; byte address is four times it
`define LVDC_IDX_CTRL      16'h1809
`define LVDC_IDX_IRQ_STAT  16'h1810
`define LVDC_IDX_IRQ_MASK  16'h1811
`define LVDC_ADDR_W        16

`define LVDC_BIT_FLAG      7
`define LVDC_BIT_ACK       6
`define LVDC_BIT_IE        5
`define LVDC_BIT_RE        4
`define LVDC_BIT_SE        3
`define LVDC_BIT_DE        2
`define LVDC_BIT_RSVD      1
`define LVDC_BIT_BG        0

`define LVDC_CTRL_RESET    8'h1C
`define LVDC_WO_MASK       8'h1C
`define LVDC_STAT_W        2
`define LVDC_RD_LATENCY    1

`endif

// ---- src/lvdc_pkg.sv ----
package lvdc_pkg;
	typedef enum logic [1:0] {
		LVDC_RUN,
		LVDC_STOP_LIGHT,
		LVDC_STOP_DEEP
	} lvdc_pwr_t;
endpackage : lvdc_pkg

// ---- src/lvdc_sync.sv ----
// three-stage synchroniser; output changes once stages 2 and 3 agree
module lvdc_sync (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic resetn,
	// data
	input  wire logic din,
	output logic      dout
);
	typedef struct packed {
		logic [2:0] sh;
		logic       q;
	} lvdc_sync_st_t;
	lvdc_sync_st_t st_ff, nxt_st;

	always_comb begin
		nxt_st    = st_ff;
		nxt_st.sh = {st_ff.sh[1:0], din};
		if (st_ff.sh[1] == st_ff.sh[2]) begin
			nxt_st.q = st_ff.sh[2];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign dout = st_ff.q;
endmodule : lvdc_sync

// ---- src/lvdc_once_bit.sv ----
`include "lvdc_params.svh"
// register bit that accepts only its first write after reset
module lvdc_once_bit #(
	parameter logic RST = 1'b0
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic resetn,
	// write
	input  wire logic wr,
	input  wire logic wdata,
	output logic      q
);
	typedef struct packed {
		logic v;
		logic done;
	} lvdc_once_st_t;
	lvdc_once_st_t st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (wr && !st_ff.done) begin
			nxt_st.v    = wdata;
			nxt_st.done = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			st_ff <= '{v: RST, done: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.v;
endmodule : lvdc_once_bit

// ---- src/lvdc_ctrl.sv ----
// Local design decision: register access over Avalon-MM.
`include "lvdc_params.svh"

// Summary of operation
// - while detection is on, a detector event shows in read-only bit 7.
// - writing one to bit 6 clears the event flag, zero leaves it alone.
// - bit 6 always reads back as zero.
// - with bit 5 set an interrupt is requested while the flag is set.
// - with bit 4 and detection on, a set flag forces a chip reset.
// - with detection on, bit 3 keeps the detector alive in stop mode.
// - bit 2 turns detection on; flag, reset and stop functions need it.
// - bit 0 drives the bandgap reference buffer enable.
// - write-once bits take only the first write after reset.
// - detector alive in stop forces the light stop, not deep power-down.
module lvdc_ctrl (
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    resetn,
	// avalon-mm slave
	input  wire logic [`LVDC_ADDR_W+1:0] avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output logic [31:0]                  avs_readdata,
	output logic                         avs_waitrequest,
	output logic [1:0]                   avs_response,
	// analogue side
	input  wire logic                    supply_low_in,
	output logic                         detect_on,
	output logic                         detect_in_stop,
	output logic                         bandgap_buffer_enable,
	// power, reset and interrupt control
	input  wire logic                    stop_request,
	input  wire logic                    deep_powerdown_select,
	output lvdc_pkg::lvdc_pwr_t          pwr_state,
	output logic                         chip_reset_req,
	output logic                         irq
);
	import lvdc_pkg::*;

	localparam logic [7:0] CTRL_RST = `LVDC_CTRL_RESET;

	typedef struct packed {
		logic                   ack_done;
		logic [31:0]            rdata;
		logic [1:0]             resp;
		logic                   flag;
		logic                   irq_en;
		logic                   bg_en;
		logic [`LVDC_STAT_W-1:0] stat;
		logic [`LVDC_STAT_W-1:0] mask;
		logic                   rst_req;
		logic                   irq_q;
		logic                   det_on;
		logic                   det_stop;
		logic                   low_q;
		lvdc_pwr_t              pwr;
	} lvdc_st_t;

	lvdc_st_t st_ff, nxt_st;

	logic       low_sync;
	logic       re_q;
	logic       se_q;
	logic       de_q;
	logic       sel_ctrl;
	logic       sel_stat;
	logic       sel_mask;
	logic       wr_lane0;
	logic       wr_ctrl;
	logic [7:0] ctrl_view;

	assign sel_ctrl = avs_address[`LVDC_ADDR_W+1:2] == `LVDC_IDX_CTRL;
	assign sel_stat = avs_address[`LVDC_ADDR_W+1:2] == `LVDC_IDX_IRQ_STAT;
	assign sel_mask = avs_address[`LVDC_ADDR_W+1:2] == `LVDC_IDX_IRQ_MASK;
	// writes land only in the answering cycle, so each access acts once
	assign wr_lane0 = avs_write && avs_byteenable[0] && st_ff.ack_done;
	assign wr_ctrl  = wr_lane0 && sel_ctrl;

	lvdc_sync u_low_sync (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.din     (supply_low_in),
		.dout    (low_sync)
	);

	// reset, stop and detect enables are write-once
	lvdc_once_bit #(.RST(CTRL_RST[`LVDC_BIT_RE])) u_once_re (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.wr      (wr_ctrl),
		.wdata   (avs_writedata[`LVDC_BIT_RE]),
		.q       (re_q)
	);

	lvdc_once_bit #(.RST(CTRL_RST[`LVDC_BIT_SE])) u_once_se (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.wr      (wr_ctrl),
		.wdata   (avs_writedata[`LVDC_BIT_SE]),
		.q       (se_q)
	);

	lvdc_once_bit #(.RST(CTRL_RST[`LVDC_BIT_DE])) u_once_de (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.wr      (wr_ctrl),
		.wdata   (avs_writedata[`LVDC_BIT_DE]),
		.q       (de_q)
	);

	always_comb begin
		ctrl_view                 = '0;
		ctrl_view[`LVDC_BIT_FLAG] = st_ff.flag;
		ctrl_view[`LVDC_BIT_ACK]  = 1'b0;
		ctrl_view[`LVDC_BIT_IE]   = st_ff.irq_en;
		ctrl_view[`LVDC_BIT_RE]   = re_q;
		ctrl_view[`LVDC_BIT_SE]   = se_q;
		ctrl_view[`LVDC_BIT_DE]   = de_q;
		ctrl_view[`LVDC_BIT_RSVD] = 1'b0;
		ctrl_view[`LVDC_BIT_BG]   = st_ff.bg_en;
	end

	always_comb begin
		nxt_st       = st_ff;
		nxt_st.low_q = low_sync;

		// one wait cycle, then answer
		if ((avs_read || avs_write) && !st_ff.ack_done) begin
			nxt_st.ack_done = 1'b1;
			nxt_st.resp     = (sel_ctrl || sel_stat || sel_mask)
				? 2'h0 : 2'h2;
			nxt_st.rdata    = '0;
			if (avs_read) begin
				if (sel_ctrl) begin
					nxt_st.rdata = {24'h000000, ctrl_view};
				end else if (sel_stat) begin
					nxt_st.rdata = {30'h0, st_ff.stat};
				end else if (sel_mask) begin
					nxt_st.rdata = {30'h0, st_ff.mask};
				end
			end
		end else begin
			nxt_st.ack_done = 1'b0;
		end

		// reserved bit 1 is not stored, so a stray one is harmless
		if (wr_ctrl) begin
			nxt_st.irq_en = avs_writedata[`LVDC_BIT_IE];
			nxt_st.bg_en  = avs_writedata[`LVDC_BIT_BG];
		end

		// ack first, then detection so a same-cycle event wins
		if (wr_ctrl && avs_writedata[`LVDC_BIT_ACK]) begin
			nxt_st.flag = 1'b0;
		end
		if (de_q && low_sync) begin
			nxt_st.flag = 1'b1;
		end

		if (wr_lane0 && sel_mask) begin
			nxt_st.mask = avs_writedata[`LVDC_STAT_W-1:0];
		end
		if (wr_lane0 && sel_stat) begin
			nxt_st.stat = st_ff.stat & ~avs_writedata[`LVDC_STAT_W-1:0];
		end
		// status bit 0: detector event; bit 1: supply recovered
		if (de_q && low_sync && !st_ff.low_q) begin
			nxt_st.stat[0] = 1'b1;
		end
		if (de_q && !low_sync && st_ff.low_q) begin
			nxt_st.stat[1] = 1'b1;
		end

		nxt_st.irq_q = (st_ff.irq_en && st_ff.flag)
			|| |(st_ff.stat & st_ff.mask);
		nxt_st.rst_req  = re_q && de_q && st_ff.flag;
		nxt_st.det_on   = de_q;
		nxt_st.det_stop = de_q && se_q;

		case (st_ff.pwr)
			LVDC_RUN: begin
				if (stop_request) begin
					// live detector needs the regulator, so stay light
					if ((de_q && se_q) || !deep_powerdown_select) begin
						nxt_st.pwr = LVDC_STOP_LIGHT;
					end else begin
						nxt_st.pwr = LVDC_STOP_DEEP;
					end
				end
			end
			LVDC_STOP_LIGHT, LVDC_STOP_DEEP: begin
				if (!stop_request) begin
					nxt_st.pwr = LVDC_RUN;
				end
			end
			default: begin
				nxt_st.pwr = LVDC_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			st_ff <= '{default: '0, pwr: LVDC_RUN};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign avs_readdata          = st_ff.rdata;
	assign avs_waitrequest       = !st_ff.ack_done;
	assign avs_response          = st_ff.resp;
	assign detect_on             = st_ff.det_on;
	assign detect_in_stop        = st_ff.det_stop;
	assign bandgap_buffer_enable = st_ff.bg_en;
	assign pwr_state             = st_ff.pwr;
	assign chip_reset_req        = st_ff.rst_req;
	assign irq                   = st_ff.irq_q;
endmodule : lvdc_ctrl

// ---- tb/lvdc_properties.sv ----
`include "lvdc_params.svh"
module lvdc_properties
	import lvdc_pkg::*;
(
	// clock and reset
	input wire logic                    ref_clk,
	input wire logic                    resetn,
	// bus
	input wire logic [`LVDC_ADDR_W+1:0] avs_address,
	input wire logic                    avs_read,
	input wire logic                    avs_write,
	input wire logic [31:0]             avs_writedata,
	input wire logic [3:0]              avs_byteenable,
	input wire logic [31:0]             avs_readdata,
	input wire logic                    avs_waitrequest,
	input wire logic [1:0]              avs_response,
	// outputs
	input wire logic                    detect_on,
	input wire logic                    detect_in_stop,
	input wire logic                    bandgap_buffer_enable,
	input wire lvdc_pwr_t               pwr_state,
	input wire logic                    chip_reset_req,
	input wire logic                    irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic [15:0] idx;
	logic        ans;
	logic        ctl;
	assign idx = avs_address[`LVDC_ADDR_W+1:2];
	assign ans = !avs_waitrequest;
	assign ctl = idx == `LVDC_IDX_CTRL;
	a_wait_answer: assert property ((avs_read || avs_write) && !ans |=> ans)
		else $error("no answer after one wait cycle");
	a_wait_release: assert property (ans |=> !ans)
		else $error("answer stood longer than one cycle");
	a_unmapped_read: assert property (ans && avs_read && !(ctl ||
		idx == `LVDC_IDX_IRQ_STAT || idx == `LVDC_IDX_IRQ_MASK)
		|-> avs_response == 2'b10 && avs_readdata == 32'h0)
		else $error("unmapped read not refused");
	a_ack_reads_zero: assert property (
		ans && avs_read && ctl |-> avs_readdata[6] == 1'b0)
		else $error("ack bit read back as one");
	a_irq_from_flag: assert property (
		ans && avs_read && ctl && avs_readdata[7] && avs_readdata[5] |-> irq)
		else $error("flag with enable set but no interrupt");
	a_reset_gated: assert property (
		!detect_on && $past(!detect_on) |-> !chip_reset_req)
		else $error("chip reset while detection off");
	a_stop_gated: assert property (detect_in_stop |-> detect_on)
		else $error("stop operation without detection");
	a_light_stop: assert property (
		detect_in_stop && $past(detect_in_stop) |-> pwr_state != LVDC_STOP_DEEP)
		else $error("deep stop entered with detector alive");
	a_bandgap_write: assert property (
		ans && avs_write && ctl && avs_byteenable[0] |-> ##2
		bandgap_buffer_enable == $past(avs_writedata[0], 2))
		else $error("bandgap enable does not follow write");
	c_irq: cover property ($rose(irq));
	c_light: cover property (pwr_state == LVDC_STOP_LIGHT);
	c_refused: cover property (ans && avs_response == 2'b10);
	c_deep: cover property (pwr_state == LVDC_STOP_DEEP);
	c_chip_reset: cover property ($rose(chip_reset_req));
endmodule : lvdc_properties
bind lvdc_ctrl lvdc_properties lvdc_properties_i (.ref_clk, .resetn,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_readdata, .avs_waitrequest, .avs_response, .detect_on,
	.detect_in_stop, .bandgap_buffer_enable, .pwr_state, .chip_reset_req,
	.irq);

// ---- tb/test_low_voltage_detect_control.sv ----
`include "lvdc_params.svh"
module test_low_voltage_detect_control;
	timeunit 1ns;
	timeprecision 1ns;
	import lvdc_pkg::*;
	logic ref_clk = 0, resetn = 0, avs_read = 0, avs_write = 0;
	logic supply_low_in = 0, stop_request = 0, deep_powerdown_select = 1;
	logic [`LVDC_ADDR_W+1:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata, q;
	logic [3:0] avs_byteenable = 4'hF;
	logic [1:0] avs_response, rs;
	logic avs_waitrequest, detect_on, detect_in_stop, bandgap_buffer_enable;
	logic chip_reset_req, irq;
	lvdc_pwr_t pwr_state;
	int miscompares = 0, samples_checked = 0, cyc = 0, seed = 32'h8824;
	int ctrl_m = 'h1C, flag_m = 0, stat_m = 0, mask_m = 0;
	lvdc_ctrl lvdc_ctrl_i (.ref_clk, .resetn, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .avs_response, .supply_low_in, .detect_on,
		.detect_in_stop, .bandgap_buffer_enable, .stop_request,
		.deep_powerdown_select, .pwr_state, .chip_reset_req, .irq);
	initial forever #20 ref_clk = ~ref_clk;
	task automatic summarize;
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk
	// a free edge first, so a release and a new request never share a step
	task automatic bus(input logic w, input logic [15:0] i, input int d);
		@(posedge ref_clk);
		avs_address <= {i, 2'b00};
		avs_writedata <= {24'h0, d[7:0]};
		avs_read <= !w;
		avs_write <= w;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		rs = avs_response;
		avs_read <= 0;
		avs_write <= 0;
	endtask : bus
	task automatic look;
		bus(0, `LVDC_IDX_CTRL, 0);
		chk(q, flag_m << 7 | ctrl_m);
		chk(irq, ctrl_m >> 5 & flag_m | (stat_m & mask_m) != 0);
		chk(chip_reset_req, ctrl_m >> 4 & ctrl_m >> 2 & flag_m);
		chk(bandgap_buffer_enable, ctrl_m & 1);
		chk(detect_in_stop, ctrl_m >> 3 & ctrl_m >> 2 & 1);
		chk(detect_on, ctrl_m >> 2 & 1);
	endtask : look
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 1000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		int v;
		repeat (16) @(posedge ref_clk);
		resetn <= 1;
		look();
		bus(0, 16'h1234, 0);
		chk(rs, 2'b10);
		bus(1, `LVDC_IDX_IRQ_MASK, 1);
		mask_m = 1;
		// bit 1 kept zero on every control write
		v = $random(seed) & 'h01 | 'h2C;
		bus(1, `LVDC_IDX_CTRL, v);
		ctrl_m = v;
		look();
		v = $random(seed) & 'h1D | 'h20;
		bus(1, `LVDC_IDX_CTRL, v);
		ctrl_m = ctrl_m & 'h1C | v & 'h21;
		look();
		supply_low_in <= 1;
		repeat (8) @(posedge ref_clk);
		supply_low_in <= 0;
		flag_m = 1;
		stat_m = 3;
		repeat (8) @(posedge ref_clk);
		look();
		bus(0, `LVDC_IDX_IRQ_STAT, 0);
		chk(q, stat_m);
		bus(1, `LVDC_IDX_CTRL, ctrl_m);
		look();
		bus(1, `LVDC_IDX_CTRL, ctrl_m | 'h40);
		flag_m = 0;
		look();
		bus(1, `LVDC_IDX_IRQ_STAT, 3);
		stat_m = 0;
		look();
		stop_request <= 1;
		repeat (4) @(posedge ref_clk);
		chk(pwr_state, LVDC_STOP_LIGHT);
		stop_request <= 0;
		// second reset opens the write-once bits again
		resetn <= 0;
		repeat (4) @(posedge ref_clk);
		resetn <= 1;
		supply_low_in <= 1;
		ctrl_m = 8'h1C;
		mask_m = 0;
		repeat (8) @(posedge ref_clk);
		supply_low_in <= 0;
		flag_m = 1;
		stat_m = 3;
		look();
		// first write after reset: stop enable off, flag acknowledged
		v = $random(seed) & 8'h01 | 8'h44;
		bus(1, `LVDC_IDX_CTRL, v);
		ctrl_m = v & 8'h3F;
		flag_m = 0;
		look();
		stop_request <= 1;
		repeat (4) @(posedge ref_clk);
		chk(pwr_state, LVDC_STOP_DEEP);
		stop_request <= 0;
		deep_powerdown_select <= 0;
		repeat (2) @(posedge ref_clk);
		stop_request <= 1;
		repeat (4) @(posedge ref_clk);
		chk(pwr_state, LVDC_STOP_LIGHT);
		stop_request <= 0;
		summarize();
	end
endmodule : test_low_voltage_detect_control
